// ===== src/standby_pkg.sv
// Constants and types shared by the standby (halt and first idle) controller.
//
// Operation
// - Any NMI or unmasked request ends halt.
// - Non-nested NMI acknowledged on halt release.
// - Interrupts disabled: wake, keep request pending.
// - Higher handler in service: wake, keep pending.
// - Lower handler in service: acknowledge on release.
// - Halt keeps ports, CPU registers, RAM.
// - Timers run in halt unless subclock-clocked; code stops them only while subclock_used_in is low.
// - Watch timer runs only from divided main; code: subclock in idle, any source in halt if subclock_used_in.
// - CRC runs in halt unless input stalls.
// - Idle keeps oscillator, PLL, flash; stops CPU, peripherals.
// - Idle keeps subclock or external clocked peripherals; code stops the watch timer on external clock.
// - Idle keeps RAM, execution stays stopped.
// - Idle release resumes at once, no wait.
// - Pending unmasked request blocks idle entry.
// - Halt instruction stops only the CPU clock.
// - Watchdog NMI, pins, any reset end halt.
// - Release-masked requests cannot end first idle.
`default_nettype none
package standby_pkg;
  localparam int          PRIO_W        = 3;
  localparam int          MODE_W        = 2;
  localparam logic [1:0]  MODE_FIRST_IDLE_STANDBY    = 2'h0;
  localparam int          SYNC_STAGES   = 3;
  localparam int          CLK_MHZ       = 250;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_IDLE
  } standby_state_t;
  typedef enum logic [1:0] {
    CLK_MAIN,
    CLK_SUB,
    CLK_EXT,
    CLK_BRG
  } clk_src_t;
endpackage
`default_nettype wire

// ===== src/clock_gate_cell.sv
// Glitch-free clock gate: enable latched while the clock is low.
`default_nettype none
module clock_gate_cell (
  input  wire logic clk_in,
  input  wire logic enable_in,
  output logic      gated_clk_out
);
  logic en_latched;

  // Transparent-low latch keeps the enable stable through the high phase.
  always_latch begin
    if (!clk_in) begin
      en_latched <= enable_in;
    end
  end

  assign gated_clk_out = clk_in & en_latched;
endmodule
`default_nettype wire

// ===== src/standby_halt_idle_control.sv
// Halt and first idle standby control: wake decision and clock gating.
`default_nettype none
module standby_halt_idle_control #(
  parameter int PRIO_W = standby_pkg::PRIO_W
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // CPU side.
  input  wire logic              halt_instr_in,
  input  wire logic              standby_trigger_bit_in,
  input  wire logic [1:0]        power_save_mode_reg_in,
  input  wire logic              irq_globally_enabled_in,
  input  wire logic              in_service_valid_in,
  input  wire logic [PRIO_W-1:0] in_service_prio_in,
  input  wire logic              nmi_in_service_in,
  // Interrupt controller side, same clock.
  input  wire logic              maskable_req_in,
  input  wire logic [PRIO_W-1:0] maskable_prio_in,
  input  wire logic              nmi_req_in,
  input  wire logic              watchdog_nmi_request_in,
  // External pins, asynchronous.
  input  wire logic              nmi_pin_in,
  input  wire logic              ext_int_pin_in,
  input  wire logic              ext_int_unmasked_in,
  // Reset sources, same clock.
  input  wire logic              reset_pin_req_in,
  input  wire logic              watchdog_reset_signal_in,
  input  wire logic              low_voltage_detector_in,
  input  wire logic              clock_monitor_in,
  // Release masks of the standby control register, 1 blocks release.
  input  wire logic              nmi2_release_mask_in,
  input  wire logic              nmi0_release_mask_in,
  input  wire logic              maskable_release_mask_in,
  // Clock sources selected for peripherals.
  input  wire logic [1:0]        general_timer_clk_sel_in,
  input  wire logic [1:0]        watchdog_clk_sel_in,
  input  wire logic [1:0]        watch_timer_clk_sel_in,
  input  wire logic              subclock_used_in,
  input  wire logic              crc_input_stall_in,
  // Results.
  output logic                   cpu_clk_out,
  output logic                   periph_clk_out,
  output logic                   cpu_clk_en_out,
  output logic                   periph_clk_en_out,
  output logic                   osc_pll_flash_en_out,
  output logic                   general_timer_run_out,
  output logic                   watchdog_run_out,
  output logic                   watch_timer_run_out,
  output logic                   crc_run_out,
  output logic                   retain_state_out,
  output logic                   system_reset_out,
  output logic                   wake_ack_out,
  output logic                   wake_retain_out,
  output logic                   halted_out,
  output logic                   idle_out
);
  // Elaboration-time checks on what the logic can serve.
  if (PRIO_W < 1 || PRIO_W > 8) begin : g_bad_prio_w
    $error("PRIO_W out of range");
  end
  // The agreement test reads stages two and three of each synchroniser.
  if (standby_pkg::SYNC_STAGES != 3) begin : g_bad_sync_stages
    $error("SYNC_STAGES must be 3");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic       nmi_pin_lvl_r;
  logic       ext_pin_lvl_r;

  assign pin_raw = {ext_int_pin_in, nmi_pin_in};

  // Both pins share one synchroniser shape, so they stay equally delayed.
  for (genvar p = 0; p < 2; p++) begin : g_pin_sync
    logic [standby_pkg::SYNC_STAGES-1:0] sync_r;
    logic                                lvl_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        sync_r <= '0;
      end else begin
        sync_r <= {sync_r[standby_pkg::SYNC_STAGES-2:0], pin_raw[p]};
      end
    end

    // A level change counts once stages two and three agree.
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        lvl_r <= 1'b0;
      end else if (sync_r[1] == sync_r[2]) begin
        lvl_r <= sync_r[2];
      end
    end

    assign pin_lvl[p] = lvl_r;
  end

  assign nmi_pin_lvl_r = pin_lvl[0];
  assign ext_pin_lvl_r = pin_lvl[1];

  // --------------------------------------------------------------------------
  // Wake sources
  // --------------------------------------------------------------------------
  function automatic logic runs_off_subclock(input logic [1:0] sel);
    runs_off_subclock = (sel == 2'(standby_pkg::CLK_SUB));
  endfunction

  // Units that count through the first idle state need a clock that stays up.
  function automatic logic runs_in_idle(input logic [1:0] sel);
    runs_in_idle = (sel == 2'(standby_pkg::CLK_SUB)) || (sel == 2'(standby_pkg::CLK_EXT));
  endfunction

  standby_pkg::standby_state_t state_r;
  standby_pkg::standby_state_t state_nxt;

  logic any_reset;
  logic nmi_any;
  logic nmi_wake_idle;
  logic mask_wake;
  logic mask_wake_idle;
  logic halt_wake;
  logic idle_wake;
  logic higher_in_service;

  assign any_reset = reset_pin_req_in | watchdog_reset_signal_in
                   | low_voltage_detector_in | clock_monitor_in;
  assign nmi_any   = nmi_req_in | nmi_pin_lvl_r | watchdog_nmi_request_in;
  assign mask_wake = maskable_req_in | (ext_pin_lvl_r & ext_int_unmasked_in);
  assign halt_wake = nmi_any | mask_wake;
  // Release masks gate only the first idle wake.
  assign nmi_wake_idle  = (watchdog_nmi_request_in & ~nmi2_release_mask_in)
                        | ((nmi_req_in | nmi_pin_lvl_r) & ~nmi0_release_mask_in);
  assign mask_wake_idle = mask_wake & ~maskable_release_mask_in;
  assign idle_wake      = nmi_wake_idle | mask_wake_idle;
  // Lower number is higher priority; an equal handler does not hold the request back.
  assign higher_in_service = in_service_valid_in
                           && (in_service_prio_in < maskable_prio_in);

  // --------------------------------------------------------------------------
  // Standby state machine
  // --------------------------------------------------------------------------
  logic idle_request;
  assign idle_request = standby_trigger_bit_in
                     && (power_save_mode_reg_in == standby_pkg::MODE_FIRST_IDLE_STANDBY);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      standby_pkg::ST_RUN: begin
        if (halt_instr_in) begin
          state_nxt = standby_pkg::ST_HALT;
        end else if (idle_request && !idle_wake) begin
          state_nxt = standby_pkg::ST_IDLE;
        end
      end
      standby_pkg::ST_HALT: begin
        if (halt_wake) begin
          state_nxt = standby_pkg::ST_RUN;
        end
      end
      standby_pkg::ST_IDLE: begin
        if (idle_wake) begin
          state_nxt = standby_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = standby_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= standby_pkg::ST_RUN;
    end else if (any_reset) begin
      state_r <= standby_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Acknowledge or retain decision on release
  // --------------------------------------------------------------------------
  logic leaving;
  // A reset source is not a wake: the CPU restarts instead of taking a request.
  assign leaving = (state_r != standby_pkg::ST_RUN)
                && (state_nxt == standby_pkg::ST_RUN) && !any_reset;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_ack_out    <= 1'b0;
      wake_retain_out <= 1'b0;
    end else begin
      wake_ack_out    <= 1'b0;
      wake_retain_out <= 1'b0;
      if (leaving) begin
        if (nmi_any && !nmi_in_service_in) begin
          wake_ack_out <= 1'b1;
        end else if (!irq_globally_enabled_in) begin
          wake_retain_out <= 1'b1;
        end else if (higher_in_service) begin
          wake_retain_out <= 1'b1;
        end else begin
          wake_ack_out <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      system_reset_out <= 1'b1;
    end else begin
      system_reset_out <= any_reset;
    end
  end

  // --------------------------------------------------------------------------
  // Clock enables and unit run decisions
  // --------------------------------------------------------------------------
  logic in_halt;
  logic in_idle;
  assign in_halt = (state_r == standby_pkg::ST_HALT);
  assign in_idle = (state_r == standby_pkg::ST_IDLE);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_clk_en_out    <= 1'b1;
      periph_clk_en_out <= 1'b1;
    end else if (any_reset) begin
      cpu_clk_en_out    <= 1'b1;
      periph_clk_en_out <= 1'b1;
    end else begin
      cpu_clk_en_out    <= (state_nxt == standby_pkg::ST_RUN);
      periph_clk_en_out <= (state_nxt != standby_pkg::ST_IDLE);
    end
  end

  // The oscillator, PLL and flash are never stopped by these two states.
  assign osc_pll_flash_en_out = 1'b1;
  // Status outputs are registered copies of the next state, so they never glitch.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      halted_out       <= 1'b0;
      idle_out         <= 1'b0;
      retain_state_out <= 1'b0;
    end else if (any_reset) begin
      halted_out       <= 1'b0;
      idle_out         <= 1'b0;
      retain_state_out <= 1'b0;
    end else begin
      halted_out       <= (state_nxt == standby_pkg::ST_HALT);
      idle_out         <= (state_nxt == standby_pkg::ST_IDLE);
      // Ports, CPU registers and RAM hold because their clock is stopped.
      retain_state_out <= (state_nxt != standby_pkg::ST_RUN);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      general_timer_run_out <= 1'b1;
      watchdog_run_out      <= 1'b1;
      watch_timer_run_out   <= 1'b1;
      crc_run_out           <= 1'b1;
    end else if (in_halt && !subclock_used_in) begin
      general_timer_run_out <= !runs_off_subclock(general_timer_clk_sel_in);
      watchdog_run_out      <= !runs_off_subclock(watchdog_clk_sel_in);
      watch_timer_run_out   <= (watch_timer_clk_sel_in == 2'(standby_pkg::CLK_BRG));
      crc_run_out           <= !crc_input_stall_in;
    end else if (in_idle) begin
      general_timer_run_out <= runs_in_idle(general_timer_clk_sel_in);
      watchdog_run_out      <= runs_in_idle(watchdog_clk_sel_in);
      watch_timer_run_out   <= (watch_timer_clk_sel_in == 2'(standby_pkg::CLK_SUB));
      crc_run_out           <= 1'b0;
    end else begin
      general_timer_run_out <= 1'b1;
      watchdog_run_out      <= 1'b1;
      watch_timer_run_out   <= 1'b1;
      crc_run_out           <= in_halt ? !crc_input_stall_in : 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Glitch-free gated clocks
  // --------------------------------------------------------------------------
  clock_gate_cell u_cpu_gate (
    .clk_in        (clk_in),
    .enable_in     (cpu_clk_en_out),
    .gated_clk_out (cpu_clk_out)
  );

  clock_gate_cell u_periph_gate (
    .clk_in        (clk_in),
    .enable_in     (periph_clk_en_out),
    .gated_clk_out (periph_clk_out)
  );
endmodule
`default_nettype wire

// ===== sim/irq_source_model.sv
// Interrupt controller stand-in that raises one maskable request after a chosen delay.
`default_nettype none
module irq_source_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       fire_in,
  input  wire logic       clear_in,
  input  wire logic       ack_in,
  input  wire logic [3:0] lat_in,
  output logic            req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic       pend_r;
  // A retained request stays up until software clears it, as the real controller does.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r   <= 4'h0;
      pend_r  <= 1'b0;
      req_out <= 1'b0;
    end else if (fire_in) begin
      cnt_r  <= lat_in;
      pend_r <= 1'b1;
    end else if (pend_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (pend_r) begin
      req_out <= 1'b1;
      pend_r  <= 1'b0;
    end else if (ack_in || clear_in) begin
      req_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/standby_chk_sva.sv
// Concurrent checks on wake decisions, standby entry and clock gating.
`default_nettype none
module standby_chk #(parameter int PRIO_W = 3) (
  input wire logic clk_in, sys_rst_in, halt_instr_in, standby_trigger_bit_in,
  input wire logic [1:0] power_save_mode_reg_in,
  input wire logic irq_globally_enabled_in, in_service_valid_in, nmi_in_service_in,
  input wire logic [PRIO_W-1:0] in_service_prio_in, maskable_prio_in,
  input wire logic maskable_req_in, nmi_req_in, watchdog_nmi_request_in, maskable_release_mask_in,
  input wire logic reset_pin_req_in, watchdog_reset_signal_in, low_voltage_detector_in, clock_monitor_in,
  input wire logic cpu_clk_en_out, periph_clk_en_out, osc_pll_flash_en_out, retain_state_out,
  input wire logic system_reset_out, wake_ack_out, wake_retain_out, halted_out, idle_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire rs = reset_pin_req_in | watchdog_reset_signal_in | low_voltage_detector_in | clock_monitor_in;
  wire nm = nmi_req_in | watchdog_nmi_request_in;
  wire run = !halted_out && !idle_out;
  wire go = standby_trigger_bit_in && power_save_mode_reg_in == 2'h0 && run && !halt_instr_in;
  // Equal priority acknowledges; only a strictly higher handler holds the request back.
  wire dec = irq_globally_enabled_in && !(in_service_valid_in && in_service_prio_in < maskable_prio_in);
  a_halt_entry: assert property (halt_instr_in && run && !rs |=> halted_out && !cpu_clk_en_out
    && periph_clk_en_out) else $error("halt entry wrong");
  a_nmi_ack: assert property (halted_out && nm && !nmi_in_service_in && !rs |=> wake_ack_out && run)
    else $error("nmi not acknowledged");
  a_mask_keep: assert property (halted_out && maskable_req_in && !nm && !rs && !dec |=>
    wake_retain_out && !wake_ack_out && run) else $error("request not retained");
  a_mask_ack: assert property (halted_out && maskable_req_in && !nm && !rs && dec |=> wake_ack_out && run)
    else $error("request not acknowledged");
  a_idle_entry: assert property (go && !maskable_req_in && !nm && !rs |=> idle_out && !cpu_clk_en_out
    && !periph_clk_en_out) else $error("idle entry wrong");
  a_idle_block: assert property (go && maskable_req_in && !maskable_release_mask_in |=> !idle_out)
    else $error("idle entered with request pending");
  a_idle_masked: assert property (idle_out && maskable_req_in && maskable_release_mask_in && !nm && !rs
    |=> idle_out) else $error("masked request released idle");
  a_idle_wake: assert property (idle_out && maskable_req_in && !maskable_release_mask_in && !rs |=> run)
    else $error("idle not released at once");
  a_idle_keeps: assert property (idle_out |-> osc_pll_flash_en_out && retain_state_out)
    else $error("idle lost oscillator or state");
  a_reset_wake: assert property (rs |=> system_reset_out && !wake_ack_out ##[0:1] run)
    else $error("reset source did not end standby");
  a_reset_clk_on: assert property (rs |=> cpu_clk_en_out && periph_clk_en_out)
    else $error("clocks not restored by reset source");
  c_retain: cover property (wake_retain_out);
  c_ack: cover property (wake_ack_out);
  c_idle_exit: cover property (idle_out ##1 !idle_out);
endmodule
bind standby_halt_idle_control standby_chk #(.PRIO_W(PRIO_W)) chk_i (.*);
`default_nettype wire

// ===== sim/tb_standby_halt_idle_control.sv
// Self-checking bench for the standby controller with a reference wake model.
`default_nettype none
module tb_standby_halt_idle_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PRIO_W = standby_pkg::PRIO_W;
  logic clk_in, sys_rst_in, halt_instr_in, standby_trigger_bit_in, irq_globally_enabled_in, in_service_valid_in;
  logic nmi_in_service_in, maskable_req_in, nmi_req_in, watchdog_nmi_request_in, nmi_pin_in, ext_int_pin_in;
  logic ext_int_unmasked_in, reset_pin_req_in, watchdog_reset_signal_in, low_voltage_detector_in, clock_monitor_in;
  logic nmi2_release_mask_in, nmi0_release_mask_in, maskable_release_mask_in, subclock_used_in, crc_input_stall_in;
  logic [1:0] power_save_mode_reg_in, general_timer_clk_sel_in, watchdog_clk_sel_in, watch_timer_clk_sel_in;
  logic [PRIO_W-1:0] in_service_prio_in, maskable_prio_in;
  logic cpu_clk_out, periph_clk_out, cpu_clk_en_out, periph_clk_en_out, osc_pll_flash_en_out, general_timer_run_out;
  logic watchdog_run_out, watch_timer_run_out, crc_run_out, retain_state_out, system_reset_out, wake_ack_out;
  logic wake_retain_out, halted_out, idle_out, fire, clr;
  logic [3:0] lat;
  logic [31:0] seed, r;
  int errors, cmp_count, k, src, exp_q[$];
  standby_halt_idle_control #(.PRIO_W(PRIO_W)) standby_halt_idle_control_i (.*);
  irq_source_model irq_source_model_i (.clk_in(clk_in), .rst_in(sys_rst_in), .fire_in(fire), .clear_in(clr),
    .ack_in(wake_ack_out), .lat_in(lat), .req_out(maskable_req_in));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference decision: 1 acknowledge, 2 wake and retain.
  function automatic int wake_model(int s, logic ei, logic isv, int isp, int mp);
    if (s != 0 || (ei && !(isv && isp < mp))) return 1;
    return 2;
  endfunction
  task automatic step(int n = 1);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(string what, logic [3:0] exp, logic [3:0] got);
    cmp_count++;
    if (exp !== got) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 24 && (halted_out !== 1'b0 || idle_out !== 1'b0); i++) step();
    if (i == 24) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic do_halt();
    halt_instr_in = 1'b1;
    step();
    halt_instr_in = 1'b0;
    step(2);
  endtask
  task automatic trig(logic [1:0] mode);
    power_save_mode_reg_in = mode;
    standby_trigger_bit_in = 1'b1;
    step();
    standby_trigger_bit_in = 1'b0;
    step(5);
  endtask
  initial begin
    {halt_instr_in, standby_trigger_bit_in, irq_globally_enabled_in, in_service_valid_in, nmi_in_service_in} = '0;
    {nmi_req_in, watchdog_nmi_request_in, nmi_pin_in, ext_int_pin_in, reset_pin_req_in, fire, clr} = '0;
    {watchdog_reset_signal_in, low_voltage_detector_in, clock_monitor_in, nmi2_release_mask_in} = '0;
    {nmi0_release_mask_in, maskable_release_mask_in, subclock_used_in, crc_input_stall_in, lat} = '0;
    {power_save_mode_reg_in, general_timer_clk_sel_in, watchdog_clk_sel_in, watch_timer_clk_sel_in} = '0;
    {in_service_prio_in, maskable_prio_in} = '0;
    ext_int_unmasked_in = 1'b1;
    errors = 0;
    cmp_count = 0;
    seed = 32'h3;
    sys_rst_in = 1'b1;
    step(12);
    sys_rst_in = 1'b0;
    for (k = 0; k < 16; k++) begin
      r = rnd();
      src = r[1:0] % 3;
      {irq_globally_enabled_in, in_service_valid_in, subclock_used_in, crc_input_stall_in} = r[5:2];
      {in_service_prio_in, maskable_prio_in} = r[11:6];
      {general_timer_clk_sel_in, watchdog_clk_sel_in, watch_timer_clk_sel_in, lat} = r[21:12];
      exp_q.push_back(wake_model(src, irq_globally_enabled_in, in_service_valid_in, in_service_prio_in,
        maskable_prio_in));
      do_halt();
      chk("halted", 1, halted_out);
      chk("cpu_en", 0, cpu_clk_en_out);
      chk("per_en", 1, periph_clk_en_out);
      chk("retain", 1, retain_state_out);
      chk("gtmr", subclock_used_in | (general_timer_clk_sel_in != 2'h1), general_timer_run_out);
      chk("wdt", subclock_used_in | (watchdog_clk_sel_in != 2'h1), watchdog_run_out);
      chk("watch", subclock_used_in | (watch_timer_clk_sel_in == 2'h3), watch_timer_run_out);
      chk("crc", !crc_input_stall_in, crc_run_out);
      chk("cpu_clk", 0, cpu_clk_out);
      chk("per_clk", 1, periph_clk_out);
      fire = (src == 0);
      nmi_req_in = (src == 1);
      watchdog_nmi_request_in = (src == 2);
      step();
      fire = 1'b0;
      wait_run();
      {nmi_req_in, watchdog_nmi_request_in} = 2'h0;
      chk("ack", exp_q[0] == 1, wake_ack_out);
      chk("keep", exp_q.pop_front() == 2, wake_retain_out);
      clr = 1'b1;
      step();
      clr = 1'b0;
      step(6);
    end
    for (k = 0; k < 4; k++) begin
      do_halt();
      {reset_pin_req_in, watchdog_reset_signal_in, low_voltage_detector_in, clock_monitor_in} = 4'(1 << k);
      step();
      chk("sysrst", 1, system_reset_out);
      chk("noack", 0, wake_ack_out);
      step();
      chk("rst_wake", 0, halted_out);
      {reset_pin_req_in, watchdog_reset_signal_in, low_voltage_detector_in, clock_monitor_in} = 4'h0;
      step(4);
    end
    for (k = 0; k < 2; k++) begin
      do_halt();
      {nmi_pin_in, ext_int_pin_in} = k ? 2'h1 : 2'h2;
      wait_run();
      chk("pin_wake", 0, halted_out);
      {nmi_pin_in, ext_int_pin_in} = 2'h0;
      step(8);
    end
    {maskable_release_mask_in, irq_globally_enabled_in, lat} = 6'h20;
    trig(2'h1);
    chk("other_mode", 0, idle_out);
    trig(2'h0);
    chk("idle", 1, idle_out);
    chk("cpu_off", 0, cpu_clk_en_out);
    chk("per_off", 0, periph_clk_en_out);
    chk("osc_on", 1, osc_pll_flash_en_out);
    chk("cpu_clk_idle", 0, cpu_clk_out);
    chk("per_clk_idle", 0, periph_clk_out);
    chk("gtmr_idle", general_timer_clk_sel_in inside {2'h1, 2'h2}, general_timer_run_out);
    chk("wdt_idle", watchdog_clk_sel_in inside {2'h1, 2'h2}, watchdog_run_out);
    chk("watch_idle", watch_timer_clk_sel_in == 2'h1, watch_timer_run_out);
    chk("crc_idle", 0, crc_run_out);
    fire = 1'b1;
    step();
    fire = 1'b0;
    step(4);
    chk("masked", 1, idle_out);
    maskable_release_mask_in = 1'b0;
    step();
    chk("idle_rel", 0, idle_out);
    chk("kept", 1, wake_retain_out);
    trig(2'h0);
    chk("blocked", 0, idle_out);
    tally_and_finish();
  end
endmodule
`default_nettype wire
